// ### pkg/ipe_pkg.sv
package ipe_pkg;
  // Special-function addresses
  localparam logic [7:0] IPE_ADDR_PRIO   = 8'hb8;
  localparam logic [7:0] IPE_ADDR_EXTEN  = 8'he6;
  // Priority register fields
  localparam int IPE_P_RSVD7 = 7;
  localparam int IPE_P_INT1  = 6;
  localparam int IPE_P_TMR3  = 5;
  localparam int IPE_P_SER   = 4;
  localparam int IPE_P_TICK  = 3;
  localparam int IPE_P_RSVD2 = 2;
  localparam int IPE_P_TMR2  = 1;
  localparam int IPE_P_INT0  = 0;
  // Extended enable fields
  localparam int IPE_E_SW1 = 4;
  localparam int IPE_E_SW0 = 3;
  localparam int IPE_E_FC  = 2;
  // Storage masks and reset values
  localparam logic [7:0] IPE_PRIO_WMASK  = 8'h7f;
  localparam logic [7:0] IPE_PRIO_RDONE  = 8'h80;
  localparam logic [7:0] IPE_EXTEN_WMASK = 8'h1c;
  localparam logic [7:0] IPE_RST_VAL     = 8'h00;
  localparam logic [2:0] IPE_BIT_ADDR_BITS = 3'h3;

  // Register-port request from the processor
  typedef struct packed {
    logic       wr;     // Byte write
    logic       bwr;    // Single-bit write
    logic [7:0] addr;   // SFR address
    logic [2:0] bitsel; // Bit index for single-bit access
    logic [7:0] wdata;  // Byte data, bit 0 used for bit writes
  } ipe_req_s;

  // Request lines from the extended sources
  typedef struct packed {
    logic fc_done;
    logic sw0;
    logic sw1;
  } ipe_src_s;
endpackage

// ### design/ipe_regs.sv
`timescale 1ns/1ps
module ipe_regs
  import ipe_pkg::*;
(
  input  wire logic     clock,           // System clock
  input  wire logic     rst,             // Async reset, high
  input  wire ipe_req_s req,             // Register access
  input  wire logic     rd_bit_req,      // Read addressed bit onto rdata[0]
  output logic [7:0]    rdata,           // Read data for req.addr
  output logic [7:0]    interrupt_priority_select, // Priority byte as read
  input  wire logic     global_irq_enable, // Global enable
  input  wire ipe_src_s src,             // Extended source requests
  output ipe_src_s      src_gated,       // Enabled extended requests
  input  wire logic     hi_req,          // Any enabled high-level request
  input  wire logic     lo_req,          // Any enabled low-level request
  input  wire logic     isr_enter,       // Processor vectors to chosen request
  input  wire logic     isr_exit,        // Return from service
  output logic          take_hi,         // Grant a high-level vector
  output logic          take_lo,         // Grant a low-level vector
  output logic          in_hi_r,         // High-level service active
  output logic          in_lo_r          // Low-level service active
);
  logic [7:0] prio_r;
  logic [7:0] exten_r;
  logic       prio_hit;
  logic       exten_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Bit-write merge, shared by both registers
  function automatic logic [7:0] merge(input logic [7:0] cur, input ipe_req_s r);
    logic [7:0] v;
    v = cur;
    if (r.bwr) begin
      v[r.bitsel] = r.wdata[0];
    end else begin
      v = r.wdata;
    end
    return v;
  endfunction

  assign prio_hit  = (req.addr == IPE_ADDR_PRIO);
  assign exten_hit = (req.addr == IPE_ADDR_EXTEN);

  ////////////////////////////////////////////////////////////////////////////
  // Priority register; bit 2 stored as plain r/w, software keeps it zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prio_r <= IPE_RST_VAL;
    end else if ((req.wr || req.bwr) && prio_hit) begin
      prio_r <= merge(prio_r, req) & IPE_PRIO_WMASK;
    end
  end

  // Extended enable; only bits 4:2 ever store, others stay zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exten_r <= IPE_RST_VAL;
    end else if ((req.wr || req.bwr) && exten_hit) begin
      exten_r <= merge(exten_r, req) & IPE_EXTEN_WMASK;
    end
  end

  // Bit 7 always reads one
  assign interrupt_priority_select = prio_r | IPE_PRIO_RDONE;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero
  always_comb begin
    logic [7:0] b;
    b = 8'h00;
    if (prio_hit) begin
      b = interrupt_priority_select;
    end else if (exten_hit) begin
      b = exten_r;
    end
    rdata = rd_bit_req ? {7'h00, b[req.bitsel]} : b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating of extended sources; global enable overrides every mask
  assign src_gated.sw1     = global_irq_enable && exten_r[IPE_E_SW1] && src.sw1;
  assign src_gated.sw0     = global_irq_enable && exten_r[IPE_E_SW0] && src.sw0;
  assign src_gated.fc_done = global_irq_enable && exten_r[IPE_E_FC]  && src.fc_done;

  ////////////////////////////////////////////////////////////////////////////
  // Preemption: high wins simultaneous requests and may interrupt low service
  assign take_hi = hi_req && !in_hi_r;
  assign take_lo = lo_req && !hi_req && !in_hi_r && !in_lo_r;

  // Service-level tracking; exit ends the innermost level unless a granted entry in the same cycle wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_hi_r <= 1'b0;
      in_lo_r <= 1'b0;
    end else if (isr_enter && take_hi) begin
      in_hi_r <= 1'b1;
    end else if (isr_enter && take_lo) begin
      in_lo_r <= 1'b1;
    end else if (isr_exit) begin
      if (in_hi_r) begin
        in_hi_r <= 1'b0;
      end else begin
        in_lo_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_rsvd7;
    @(posedge clock) disable iff (rst) interrupt_priority_select[IPE_P_RSVD7];
  endproperty
  a_rsvd7: assert property (p_rsvd7) else $error("priority bit 7 not one");

  property p_prio_bwr;
    @(posedge clock) disable iff (rst)
      req.bwr && prio_hit && req.bitsel != 3'h7 |=> prio_r[$past(req.bitsel)] == $past(req.wdata[0]);
  endproperty
  a_prio_bwr: assert property (p_prio_bwr) else $error("bit write lost");

  property p_prio_byte;
    @(posedge clock) disable iff (rst)
      req.wr && !req.bwr && prio_hit |=> prio_r[6:0] == $past(req.wdata[6:0]);
  endproperty
  a_prio_byte: assert property (p_prio_byte) else $error("byte write lost");

  property p_ext_rsvd;
    @(posedge clock) disable iff (rst) exten_r[7:5] == 3'h0 && exten_r[1:0] == 2'h0;
  endproperty
  a_ext_rsvd: assert property (p_ext_rsvd) else $error("extended reserved bits set");

  property p_ea_override;
    @(posedge clock) disable iff (rst) !global_irq_enable |-> src_gated == '0;
  endproperty
  a_ea_override: assert property (p_ea_override) else $error("request passed without global enable");

  property p_fc_gate;
    @(posedge clock) disable iff (rst)
      global_irq_enable && src.fc_done |-> src_gated.fc_done == exten_r[IPE_E_FC];
  endproperty
  a_fc_gate: assert property (p_fc_gate) else $error("fc gate wrong");

  property p_sw_gate;
    @(posedge clock) disable iff (rst)
      src_gated.sw1 |-> exten_r[IPE_E_SW1] && src.sw1;
  endproperty
  a_sw_gate: assert property (p_sw_gate) else $error("sw1 gate wrong");

  property p_no_preempt_hi;
    @(posedge clock) disable iff (rst) in_hi_r |-> !take_hi && !take_lo;
  endproperty
  a_no_preempt_hi: assert property (p_no_preempt_hi) else $error("high service preempted");

  property p_hi_first;
    @(posedge clock) disable iff (rst) hi_req && lo_req && !in_hi_r |-> take_hi && !take_lo;
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("low served before high");

  property p_ext_rd;
    @(posedge clock) disable iff (rst) exten_hit && !rd_bit_req |-> rdata == exten_r;
  endproperty
  a_ext_rd: assert property (p_ext_rd) else $error("extended read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Field checks: each level select follows a byte write at its own position
  property p_lvl_int1;
    @(posedge clock) disable iff (rst)
      req.wr && !req.bwr && prio_hit |=> prio_r[IPE_P_INT1] == $past(req.wdata[IPE_P_INT1]);
  endproperty
  a_lvl_int1: assert property (p_lvl_int1) else $error("edge input 1 level lost");

  property p_lvl_tmr3;
    @(posedge clock) disable iff (rst)
      req.wr && !req.bwr && prio_hit |=> prio_r[IPE_P_TMR3] == $past(req.wdata[IPE_P_TMR3]);
  endproperty
  a_lvl_tmr3: assert property (p_lvl_tmr3) else $error("timer 3 level lost");

  property p_lvl_ser;
    @(posedge clock) disable iff (rst)
      req.wr && !req.bwr && prio_hit |=> prio_r[IPE_P_SER] == $past(req.wdata[IPE_P_SER]);
  endproperty
  a_lvl_ser: assert property (p_lvl_ser) else $error("serializer level lost");

  property p_lvl_tick;
    @(posedge clock) disable iff (rst)
      req.wr && !req.bwr && prio_hit |=> prio_r[IPE_P_TICK] == $past(req.wdata[IPE_P_TICK]);
  endproperty
  a_lvl_tick: assert property (p_lvl_tick) else $error("tick clock level lost");

  property p_lvl_tmr2;
    @(posedge clock) disable iff (rst)
      req.wr && !req.bwr && prio_hit |=> prio_r[IPE_P_TMR2] == $past(req.wdata[IPE_P_TMR2]);
  endproperty
  a_lvl_tmr2: assert property (p_lvl_tmr2) else $error("timer 2 level lost");

  property p_lvl_int0;
    @(posedge clock) disable iff (rst)
      req.wr && !req.bwr && prio_hit |=> prio_r[IPE_P_INT0] == $past(req.wdata[IPE_P_INT0]);
  endproperty
  a_lvl_int0: assert property (p_lvl_int0) else $error("edge input 0 level lost");

  ////////////////////////////////////////////////////////////////////////////
  // Gating and decode checks; a masked source must stay quiet even when requesting
  property p_sw0_pass;
    @(posedge clock) disable iff (rst)
      global_irq_enable && exten_r[IPE_E_SW0] && src.sw0 |-> src_gated.sw0;
  endproperty
  a_sw0_pass: assert property (p_sw0_pass) else $error("sw0 request dropped");

  property p_sw0_mask;
    @(posedge clock) disable iff (rst)
      !exten_r[IPE_E_SW0] |-> !src_gated.sw0;
  endproperty
  a_sw0_mask: assert property (p_sw0_mask) else $error("masked sw0 passed");

  property p_sw1_pass;
    @(posedge clock) disable iff (rst)
      global_irq_enable && exten_r[IPE_E_SW1] && src.sw1 |-> src_gated.sw1;
  endproperty
  a_sw1_pass: assert property (p_sw1_pass) else $error("sw1 request dropped");

  property p_unmapped_wr;
    @(posedge clock) disable iff (rst)
      (req.wr || req.bwr) && !prio_hit |=> $stable(prio_r);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) else $error("priority changed by foreign write");

  property p_prio_rd;
    @(posedge clock) disable iff (rst)
      prio_hit && !rd_bit_req |-> rdata == interrupt_priority_select;
  endproperty
  a_prio_rd: assert property (p_prio_rd) else $error("priority read wrong");

  property p_bit_rd;
    @(posedge clock) disable iff (rst)
      prio_hit && rd_bit_req |-> rdata == {7'h00, interrupt_priority_select[req.bitsel]};
  endproperty
  a_bit_rd: assert property (p_bit_rd) else $error("priority bit read wrong");

  property p_unmapped_rd;
    @(posedge clock) disable iff (rst)
      !prio_hit && !exten_hit |-> rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  // Reset check runs without disable, from the second reset edge on, once the async clear has settled
  property p_rst_clear;
    @(posedge clock)
      rst && $past(rst) |-> prio_r == IPE_RST_VAL && exten_r == IPE_RST_VAL && !in_hi_r && !in_lo_r;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("state not cleared in reset");

  ////////////////////////////////////////////////////////////////////////////
  // Service-level checks
  property p_lo_no_nest;
    @(posedge clock) disable iff (rst)
      in_lo_r |-> !take_lo;
  endproperty
  a_lo_no_nest: assert property (p_lo_no_nest) else $error("low preempted low service");

  property p_hi_preempts_lo;
    @(posedge clock) disable iff (rst)
      in_lo_r && !in_hi_r && hi_req |-> take_hi;
  endproperty
  a_hi_preempts_lo: assert property (p_hi_preempts_lo) else $error("high blocked in low service");

  property p_hi_enter;
    @(posedge clock) disable iff (rst)
      isr_enter && take_hi |=> in_hi_r;
  endproperty
  a_hi_enter: assert property (p_hi_enter) else $error("high service not entered");

  property p_lo_enter;
    @(posedge clock) disable iff (rst)
      isr_enter && take_lo |=> in_lo_r;
  endproperty
  a_lo_enter: assert property (p_lo_enter) else $error("low service not entered");

  property p_exit_inner;
    @(posedge clock) disable iff (rst)
      isr_exit && !isr_enter && in_hi_r |=> !in_hi_r && in_lo_r == $past(in_lo_r);
  endproperty
  a_exit_inner: assert property (p_exit_inner) else $error("exit did not end inner level");

  c_preempt:  cover property (@(posedge clock) disable iff (rst) in_lo_r && take_hi);
  c_bitwrite: cover property (@(posedge clock) disable iff (rst) req.bwr && prio_hit);
  c_fc:       cover property (@(posedge clock) disable iff (rst) src_gated.fc_done);
  c_hi_first: cover property (@(posedge clock) disable iff (rst) hi_req && lo_req && take_hi);
  c_nested:   cover property (@(posedge clock) disable iff (rst) isr_exit && in_hi_r && in_lo_r);
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_top
  import ipe_pkg::*;
;
  logic        clock = 1'b0; // 200 MHz system clock
  logic        rst;          // Async reset, high
  ipe_req_s    req;          // Register access
  logic        rd_bit_req;   // Bit read select
  logic        g;            // Global enable
  ipe_src_s    src;          // Extended source requests
  logic        hi;           // High-level request summary
  logic        lo;           // Low-level request summary
  logic        en;           // Vector taken
  logic        ex;           // Return from service
  logic [7:0]  rdata;
  logic [7:0]  prio;
  ipe_src_s    src_gated;
  logic        take_hi;
  logic        take_lo;
  logic        in_hi_r;
  logic        in_lo_r;
  int          n_errors = 0;
  int          compares = 0;
  logic [22:0] notes[$];     // Expected outputs, oldest first
  logic [22:0] n;
  logic [31:0] seed = 32'h2e64;
  logic [6:0]  p_r;          // Shadow of priority bits 6:0
  logic [7:0]  e_r;          // Shadow of extended enable
  logic        hi_s;         // Shadow of high service state
  logic        lo_s;         // Shadow of low service state
  logic        th;           // Expected high grant this cycle
  logic        tl;           // Expected low grant this cycle

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #2.5 clock = ~clock;

  ipe_regs ipe_regs_inst (.clock(clock), .rst(rst), .req(req), .rd_bit_req(rd_bit_req), .rdata(rdata),
    .interrupt_priority_select(prio), .global_irq_enable(g), .src(src), .src_gated(src_gated), .hi_req(hi),
    .lo_req(lo), .isr_enter(en), .isr_exit(ex), .take_hi(take_hi), .take_lo(take_lo), .in_hi_r(in_hi_r),
    .in_lo_r(in_lo_r));

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One cycle: fold last edge into the shadow, drive new random inputs, note the expectation
  task step;
    logic [7:0] rd;
    @(posedge clock);
    #1;
    if (req.bwr) begin
      if (req.addr == IPE_ADDR_PRIO && req.bitsel != 3'h7) p_r[req.bitsel] = req.wdata[0];
    end else if (req.wr && req.addr == IPE_ADDR_PRIO) p_r = req.wdata[6:0];
    else if (req.wr && req.addr == IPE_ADDR_EXTEN) e_r = req.wdata & 8'h1c;
    if (en && th) hi_s = 1'b1;
    else if (en && tl) lo_s = 1'b1;
    if (ex && hi_s) hi_s = 1'b0;
    else if (ex) lo_s = 1'b0;
    seed = lfsr(seed);
    // Unmapped addresses come from the random byte, so reads of nothing are mixed in
    req.addr = (seed[1:0] == 2'h0) ? seed[15:8] : (seed[2] ? IPE_ADDR_PRIO : IPE_ADDR_EXTEN);
    req.wr = seed[3];
    req.bwr = seed[4] && req.addr == IPE_ADDR_PRIO;
    req.bitsel = seed[7:5];
    req.wdata = seed[23:16] & ((req.addr == IPE_ADDR_PRIO) ? 8'hfb : 8'hfc);
    req.wdata[0] = req.wdata[0] & !(req.bwr && req.bitsel == 3'h2);
    rd_bit_req = seed[24] && req.addr == IPE_ADDR_PRIO;
    g = seed[25];
    src = seed[28:26];
    hi = seed[29];
    lo = seed[30];
    en = seed[31];
    ex = !seed[31] && seed[0] && seed[8];
    rd = (req.addr == IPE_ADDR_PRIO) ? {1'b1, p_r} : ((req.addr == IPE_ADDR_EXTEN) ? e_r : 8'h00);
    if (rd_bit_req) rd = {7'h0, rd[req.bitsel]};
    th = hi && !hi_s;
    tl = lo && !hi && !hi_s && !lo_s;
    notes.push_back({rd, 1'b1, p_r, src & {3{g}} & {e_r[2], e_r[3], e_r[4]}, th, tl, hi_s, lo_s});
  endtask

  // Mid-run reset with idle inputs; shadow clears at once, as the async reset does, and every reset cycle is noted
  task do_reset;
    @(posedge clock);
    #1;
    rst = 1'b1;
    req = '0;
    rd_bit_req = 1'b0;
    g = 1'b0;
    src = '0;
    hi = 1'b0;
    lo = 1'b0;
    en = 1'b0;
    ex = 1'b0;
    p_r = '0;
    e_r = '0;
    hi_s = 1'b0;
    lo_s = 1'b0;
    th = 1'b0;
    tl = 1'b0;
    repeat (6) begin
      notes.push_back({8'h00, 1'b1, 7'h00, 3'h0, 4'h0});
      @(posedge clock);
    end
    #1 rst = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: outputs other than in_hi_r and in_lo_r are combinational, so compare at the falling edge once settled
  always @(negedge clock) begin
    if (notes.size() > 0) begin
      n = notes.pop_front();
      `CHK(rdata, n[22:15])
      `CHK(prio, n[14:7])
      `CHK(src_gated, n[6:4])
      `CHK({take_hi, take_lo, in_hi_r, in_lo_r}, n[3:0])
    end
  end

  // Watchdog so a stuck run still reaches the verdict
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    rd_bit_req = 1'b0;
    g = 1'b0;
    src = '0;
    hi = 1'b0;
    lo = 1'b0;
    en = 1'b0;
    ex = 1'b0;
    p_r = '0;
    e_r = '0;
    hi_s = 1'b0;
    lo_s = 1'b0;
    th = 1'b0;
    tl = 1'b0;
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    repeat (400) step();
    do_reset();
    repeat (400) step();
    finish_test;
  end
endmodule
